// File: include/arsp_pkg.sv
// Package: constants and carrier types for the result serial/parallel port
package arsp_pkg;

   // ----------------------------------------
   // Sizes and counts
   // ----------------------------------------
   localparam int RESULT_WIDTH = 16;               // Bits in one conversion result
   localparam int CHAIN_DELAY_PERIODS = 16;        // Shift periods before chained data
   localparam int SYNC_STAGES = 2;                 // Flip-flops in each pin synchroniser
   localparam int INT_CLK_HALF_CYCLES = 4;         // Core cycles per internal clock half
   localparam logic [15:0] RESULT_RESET = 16'h0000; // Result register after reset
   localparam logic [4:0] BIT_COUNT_RESET = 5'h00;   // Bit counter after reset
   localparam logic [4:0] BIT_COUNT_LAST = 5'h10;    // Counter value once all bits are out

   // ----------------------------------------
   // Shift engine states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ARSP_IDLE = 3'b001,   // No read in progress
      ARSP_SHIFT = 3'b010,  // Result bits leaving
      ARSP_CHAIN = 3'b100   // Chained data passing through
   } arsp_state_e;

   // ----------------------------------------
   // Pin group of one two-way pin
   // ----------------------------------------
   typedef struct packed {
      logic out;  // Level driven
      logic oe;   // High while driving
   } arsp_pin_s;

   // ----------------------------------------
   // Mode straps sampled into the core domain
   // ----------------------------------------
   typedef struct packed {
      logic serial;   // Serial port selected
      logic ext_clk;  // Host supplies the shift clock
      logic invert;   // Shift clock inverted
      logic straight; // Straight binary coding
   } arsp_mode_s;

endpackage

// File: src/arsp_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module arsp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // ----------------------------------------
   // Stages
   // ----------------------------------------
   logic [WIDTH-1:0] meta_reg; // First stage, read only by second

   // Two stage capture
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// File: src/arsp_port.sv
// Result port pins seven to nine: parallel bits or serial shift port
`timescale 1ns/1ps
`default_nettype none
module arsp_port
   import arsp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic port_style_select,      // Pin: high serial
   input wire logic clock_source_select,    // Pin: high external clock
   input wire logic shift_clock_invert,     // Pin: invert shift clock
   input wire logic output_coding_select,   // Pin: high straight binary
   input wire logic chip_select_n,          // Pin: chip select
   input wire logic read_strobe_n,          // Pin: read strobe
   input wire logic conv_start,             // Core: conversion begins, pulse
   input wire logic conv_done,              // Core: result ready, pulse
   input wire logic [15:0] conv_result,     // Core: result with conv_done
   input wire logic [2:0] par_bits,         // Core: parallel bits 9..7 of result
   input wire logic rd_timing_in,           // Pin seven input level
   input wire logic sclk_in,                // Pin nine input level
   output arsp_pin_s parallel_bit_seven,    // Pin seven drive
   output arsp_pin_s parallel_bit_eight,    // Pin eight drive
   output arsp_pin_s parallel_bit_nine,     // Pin nine drive
   output logic busy                        // Conversion in progress
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [6:0] raw_pins;  // Outside levels
   logic [6:0] sync_pins; // Synchronised levels
   // Read request is synced active high so that reset leaves every output released
   assign raw_pins = {port_style_select, clock_source_select, shift_clock_invert,
                      output_coding_select, ~(chip_select_n | read_strobe_n), rd_timing_in,
                      sclk_in};
   arsp_sync #(.WIDTH(7)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in(raw_pins),
      .sync_out(sync_pins)
   );

   // ----------------------------------------
   // Decoded mode
   // ----------------------------------------
   arsp_mode_s mode;     // Mode straps
   wire read_en;         // Select and strobe both low
   wire chain_lvl;       // Chain or read-timing level
   wire sclk_lvl;        // Host clock level
   assign mode = '{serial: sync_pins[6], ext_clk: sync_pins[5], invert: sync_pins[4],
                   straight: sync_pins[3]};
   assign read_en = sync_pins[2];
   assign chain_lvl = sync_pins[1];
   assign sclk_lvl = sync_pins[0];

   // ----------------------------------------
   // Result register and busy
   // ----------------------------------------
   logic [15:0] result_reg; // Held result
   logic busy_reg;          // Busy flag
   logic fresh_reg;         // Result not yet read

   // Format select: invert MSB for two's complement
   function automatic logic [15:0] code_fn(input logic [15:0] r, input logic straight);
      code_fn = straight ? r : {~r[15], r[14:0]};
   endfunction
   logic [15:0] coded; // Result in the selected coding
   assign coded = code_fn(result_reg, mode.straight);

   // Latch result, track busy
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_reg <= RESULT_RESET;
         busy_reg <= 1'b0;
      end else begin
         if (conv_done) begin
            result_reg <= conv_result;
         end
         if (conv_start) begin
            busy_reg <= 1'b1;
         end else if (conv_done) begin
            busy_reg <= 1'b0;
         end
      end
   end
   assign busy = busy_reg;

   // ----------------------------------------
   // Shift clock edges
   // ----------------------------------------
   arsp_state_e state_reg, state_next; // Engine state
   logic sclk_d_reg;       // Previous host clock
   logic [2:0] div_reg;    // Internal clock divider
   logic int_clk_reg;      // Internal shift clock
   wire host_rise;         // Host clock rose
   wire host_fall;         // Host clock fell
   wire launch_edge;       // Edge that changes data
   wire int_fall;          // Internal clock falls next
   assign host_rise = sclk_lvl & ~sclk_d_reg;
   assign host_fall = ~sclk_lvl & sclk_d_reg;
   assign int_fall = int_clk_reg && div_reg == 3'(INT_CLK_HALF_CYCLES - 1);
   // Host clock: data launched on rising edge, or falling when inverted; internal clock: on its falling edge
   assign launch_edge = mode.ext_clk ? (mode.invert ? host_fall : host_rise)
                                     : int_fall;

   // Edge detector and internal divider
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_reg <= 1'b0;
         div_reg <= 3'h0;
         int_clk_reg <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_lvl;
         if (state_reg == ARSP_IDLE || div_reg == 3'(INT_CLK_HALF_CYCLES - 1)) begin
            div_reg <= 3'h0;
         end else begin
            div_reg <= div_reg + 3'h1;
         end
         if (state_reg == ARSP_IDLE) begin
            int_clk_reg <= 1'b0;
         end else if (div_reg == 3'(INT_CLK_HALF_CYCLES - 1)) begin
            int_clk_reg <= ~int_clk_reg;
         end
      end
   end

   // ----------------------------------------
   // Shift engine
   // ----------------------------------------
   logic [15:0] shift_reg;             // Outgoing bits
   logic [4:0] count_reg;              // Bits launched
   logic sdo_reg;                      // Serial output bit
   wire may_start;                     // Read may begin
   wire start;                         // Read begins now
   // Internal clock: read-timing high allows reads while busy, low only when idle; external clock ignores it
   assign may_start = mode.ext_clk ? fresh_reg
                     : (chain_lvl ? (fresh_reg | busy_reg)
                                  : (fresh_reg & ~busy_reg));
   assign start = mode.serial && read_en && state_reg == ARSP_IDLE && may_start;

   // Next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ARSP_IDLE: begin
            if (start) begin
               state_next = ARSP_SHIFT;
            end
         end
         ARSP_SHIFT: begin
            if (!read_en) begin
               state_next = ARSP_IDLE;
            end else if (launch_edge && count_reg == BIT_COUNT_LAST) begin
               state_next = mode.ext_clk ? ARSP_CHAIN : ARSP_IDLE;
            end
         end
         ARSP_CHAIN: begin
            if (!read_en) begin
               state_next = ARSP_IDLE;
            end
         end
         default: state_next = ARSP_IDLE;
      endcase
   end

   // Shift data MSB first, then pass chained input with external clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ARSP_IDLE;
         shift_reg <= RESULT_RESET;
         count_reg <= BIT_COUNT_RESET;
         sdo_reg <= 1'b0;
         fresh_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (start) begin
            shift_reg <= {coded[14:0], 1'b0};
            sdo_reg <= coded[15];
            count_reg <= 5'h1;
         end else if (launch_edge && state_reg == ARSP_SHIFT) begin
            shift_reg <= {shift_reg[14:0], 1'b0};
            // Sixteenth launch edge: all result bits have stood, pass chain with external clock, else drive 0
            if (count_reg == BIT_COUNT_LAST) begin
               sdo_reg <= mode.ext_clk ? chain_lvl : 1'b0;
            end else begin
               sdo_reg <= shift_reg[15];
            end
            count_reg <= count_reg + 5'h1;
         end else if (launch_edge && state_reg == ARSP_CHAIN) begin
            sdo_reg <= chain_lvl;
         end
         if (conv_done) begin
            fresh_reg <= 1'b1;
         end else if (start) begin
            fresh_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   logic [2:0] par_reg; // Registered parallel bits
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         par_reg <= 3'h0;
      end else begin
         par_reg <= par_bits;
      end
   end
   wire par_en; // Parallel outputs driving
   assign par_en = ~mode.serial & read_en;
   assign parallel_bit_seven = '{out: par_reg[0], oe: par_en};
   assign parallel_bit_eight = '{out: mode.serial ? sdo_reg : par_reg[1],
                                 oe: read_en};
   assign parallel_bit_nine = '{out: mode.serial ? (int_clk_reg ^ mode.invert) : par_reg[2],
                                oe: par_en | (mode.serial & ~mode.ext_clk & read_en)};

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_last_bit;
      state_reg == ARSP_SHIFT && launch_edge && count_reg == BIT_COUNT_LAST;
   endsequence
   a_busy_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      conv_done && !conv_start |=> !busy) else $error("busy not cleared");
   a_busy_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      conv_start |=> busy) else $error("busy not set");
   a_chain_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_last_bit ##0 (mode.ext_clk && read_en) |=> state_reg == ARSP_CHAIN)
      else $error("no chain after 16 bits");
   a_par_seven: assert property (@(posedge core_clk) disable iff (!rst_n)
      mode.serial |-> !parallel_bit_seven.oe) else $error("pin seven driven in serial");
   a_par_en: assert property (@(posedge core_clk) disable iff (!rst_n)
      !read_en |-> !parallel_bit_eight.oe && !parallel_bit_nine.oe)
      else $error("output without read");
   a_clk_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
      mode.serial && mode.ext_clk |-> !parallel_bit_nine.oe)
      else $error("clock driven in external mode");
   a_wait_conv: assert property (@(posedge core_clk) disable iff (!rst_n)
      start && !mode.ext_clk && !chain_lvl |-> !busy_reg)
      else $error("read during conversion");
   a_msb_first: assert property (@(posedge core_clk) disable iff (!rst_n)
      start |=> sdo_reg == $past(coded[15]))
      else $error("first bit not msb");
   a_hold_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
      !mode.ext_clk && !int_fall && !start && $stable(mode) |=> $stable(sdo_reg))
      else $error("bit changed off edge");
endmodule
`default_nettype wire

// File: bench/arsp_host_model.sv
// Host model: drives link clock and pin seven, captures serial result bits
`timescale 1ns/1ps
`default_nettype none
module arsp_host_model
   import arsp_pkg::*;
(
   input wire logic core_clk,
   input wire logic ext_mode,
   input wire logic invert,
   input wire logic run,
   input wire logic listen,
   input wire logic drive_seven,
   input wire logic level_seven,
   input wire arsp_pin_s parallel_bit_seven,
   input wire arsp_pin_s parallel_bit_eight,
   input wire arsp_pin_s parallel_bit_nine,
   output logic rd_timing_in,
   output logic sclk_in,
   output logic [31:0] word,
   output logic [5:0] cnt
);
   logic float_reg = 1'b0; // Undriven line pattern, flips every cycle
   logic sclk_host;        // Host clock level
   logic sdo;              // Resolved serial result line
   always @(posedge core_clk) float_reg <= ~float_reg;
   // ----------------------------------------
   // Wire levels from every party's enable
   // ----------------------------------------
   assign rd_timing_in = parallel_bit_seven.oe ? parallel_bit_seven.out :
      drive_seven ? level_seven : float_reg;
   assign sclk_in = parallel_bit_nine.oe ? parallel_bit_nine.out :
      ext_mode ? sclk_host : float_reg;
   assign sdo = parallel_bit_eight.oe ? parallel_bit_eight.out : float_reg;
   // Link clock idles away from the sample level, stands still when not run
   initial begin
      sclk_host = 1'b1;
      #37;
      forever begin
         #400;
         sclk_host = (run && ext_mode) ? ~sclk_host : ~invert;
      end
   end
   // Capture on the sample edge of the link clock
   always @(sclk_in, listen) begin
      if (!listen) begin
         word = 32'h0000_0000;
         cnt = 6'h00;
      end else if ((ext_mode || parallel_bit_nine.oe) &&
         sclk_in === (ext_mode ? invert : ~invert)) begin
         word = {word[30:0], sdo};
         cnt = cnt + 6'h01;
      end
   end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Testbench: pins in parallel, external and internal serial modes
`timescale 1ns/1ps
`default_nettype none
module testbench
   import arsp_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic port_style_select = 1'b0;
   logic clock_source_select = 1'b0;
   logic shift_clock_invert = 1'b0;
   logic output_coding_select = 1'b1;
   logic chip_select_n = 1'b1;
   logic read_strobe_n = 1'b1;
   logic conv_start = 1'b0;
   logic conv_done = 1'b0;
   logic [15:0] conv_result = 16'h0000;
   logic [2:0] par_bits = 3'h0;
   logic rd_timing_in, sclk_in, busy;
   arsp_pin_s p7, p8, p9; // Pin drives seven to nine
   logic run = 1'b0;
   logic listen = 1'b0;
   logic drive_seven = 1'b0;
   logic level_seven = 1'b0;
   logic [31:0] word;
   logic [5:0] cnt;
   int errors = 0;
   int checked = 0;
   always #50 core_clk = ~core_clk;
   arsp_port DUT (.core_clk(core_clk), .rst_n(rst_n), .port_style_select(port_style_select),
      .clock_source_select(clock_source_select), .shift_clock_invert(shift_clock_invert),
      .output_coding_select(output_coding_select), .chip_select_n(chip_select_n),
      .read_strobe_n(read_strobe_n), .conv_start(conv_start), .conv_done(conv_done),
      .conv_result(conv_result), .par_bits(par_bits), .rd_timing_in(rd_timing_in),
      .sclk_in(sclk_in), .parallel_bit_seven(p7), .parallel_bit_eight(p8),
      .parallel_bit_nine(p9), .busy(busy));
   arsp_host_model HOST (.core_clk(core_clk), .ext_mode(clock_source_select),
      .invert(shift_clock_invert), .run(run), .listen(listen), .drive_seven(drive_seven),
      .level_seven(level_seven), .parallel_bit_seven(p7), .parallel_bit_eight(p8),
      .parallel_bit_nine(p9), .rd_timing_in(rd_timing_in), .sclk_in(sclk_in),
      .word(word), .cnt(cnt));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wait_cnt(input logic [5:0] n);
      int i;
      for (i = 0; i < 3000 && cnt !== n; i++) tick(1);
      if (i == 3000) begin
         check("bit count", cnt, n);
         report_and_stop();
      end
   endtask
   task automatic setup(input logic ser, ext, inv, code, lvl);
      port_style_select = ser;
      clock_source_select = ext;
      shift_clock_invert = inv;
      output_coding_select = code;
      level_seven = lvl;
      drive_seven = ser;
      tick(6);
   endtask
   task automatic start_conv();
      conv_start = 1'b1;
      tick(1);
      conv_start = 1'b0;
      tick(2);
      check("busy raised", busy, 1'b1);
   endtask
   task automatic finish_conv(input logic [15:0] r);
      conv_result = r;
      conv_done = 1'b1;
      tick(1);
      conv_done = 1'b0;
      tick(2);
      check("busy lowered", busy, 1'b0);
   endtask
   task automatic read_bits(input logic [5:0] n);
      listen = 1'b1;
      chip_select_n = 1'b0;
      read_strobe_n = 1'b0;
      tick(8);
      run = 1'b1;
      wait_cnt(n);
      run = 1'b0;
   endtask
   task automatic release_bus();
      chip_select_n = 1'b1;
      read_strobe_n = 1'b1;
      tick(6);
      listen = 1'b0;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_parallel();
      logic [2:0] v;
      setup(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      for (int k = 0; k < 2; k++) begin
         v = k ? 3'h2 : 3'h5;
         par_bits = v;
         chip_select_n = 1'b0;
         read_strobe_n = 1'b0;
         tick(4);
         check("parallel pins", {p9, p8, p7}, {v[2], 1'b1, v[1], 1'b1, v[0], 1'b1});
         read_strobe_n = 1'b1;
         tick(4);
         check("parallel off", {p9.oe, p8.oe, p7.oe}, 3'h0);
         chip_select_n = 1'b1;
         tick(1);
      end
   endtask
   task automatic t_ext(input logic inv, code, lvl, input logic [15:0] r);
      setup(1'b1, 1'b1, inv, code, lvl);
      start_conv();
      finish_conv(r);
      read_bits(6'h11);
      check("ext word", word[16:0], {r ^ (code ? 16'h0000 : 16'h8000), lvl});
      check("ext pin dirs", {p7.oe, p9.oe, p8.oe}, 3'h1);
      release_bus();
   endtask
   task automatic t_int_after();
      setup(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      start_conv();
      finish_conv(16'h8001);
      read_bits(6'h10);
      check("int word", word[15:0], 16'h8001);
      check("int pin dirs", {p7.oe, p9.oe}, 2'h1);
      release_bus();
   endtask
   task automatic t_int_during();
      setup(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
      start_conv();
      read_bits(6'h10);
      check("busy while shifting", busy, 1'b1);
      check("word during conv", word[15:0], 16'h8001);
      release_bus();
      finish_conv(16'h1234);
      level_seven = 1'b0;
      tick(4);
      start_conv();
      listen = 1'b1;
      chip_select_n = 1'b0;
      read_strobe_n = 1'b0;
      tick(40);
      check("held while busy", cnt, 6'h00);
      finish_conv(16'h4321);
      wait_cnt(6'h10);
      check("word after conv", word[15:0], 16'h4321);
      release_bus();
   endtask
   // Main sequence: reset, then every scenario
   initial begin
      tick(10);
      check("reset pins", {p9, p8, p7, busy}, 7'h00);
      rst_n = 1'b1;
      tick(3);
      t_parallel();
      t_ext(1'b0, 1'b1, 1'b1, 16'hA5C3);
      t_ext(1'b1, 1'b0, 1'b0, 16'h3C5A);
      t_int_after();
      t_int_during();
      report_and_stop();
   end
endmodule
`default_nettype wire
